//--- inc/int_status_regs.svh
`ifndef INT_STATUS_REGS_SVH
`define INT_STATUS_REGS_SVH

// byte offsets on the register port
`define CTL_MSB_OFS      8'h10
`define CTL_LSB_OFS      8'h11
`define SMASK_MSB_OFS    8'h12
`define SMASK_LSB_OFS    8'h13
`define SRC_MSB_OFS      8'h14
`define SRC_LSB_OFS      8'h15
`define GEN_MSB_OFS      8'h16
`define GEN_MID_OFS      8'h17
`define GEN_LSB_OFS      8'h18
`define GFL_MSB_OFS      8'h19
`define GFL_MID_OFS      8'h1a
`define GFL_LSB_OFS      8'h1b

// interrupt_control field positions
`define CTL_GLOBAL_EN_BIT 0
`define CTL_TYPE_BIT      1
`define CTL_POL_BIT       2

// source bit carrying the gpio controller
`define SRC_GPIO_BIT      8

// reset values
`define CTL_RST          3'h0
`define SRC_MASK_RST     9'h000
`define SRC_FLAGS_RST    9'h000
`define GPIO_MASK_RST    24'h000000
`define GPIO_FLAGS_RST   24'h000000
`define RD_DATA_RST      8'h00
`define INT_PIN_RST      1'b1

// edge pulse timing: longest time, rounded down
`define CLK_PERIOD_NS    25
`define EDGE_PULSE_NS    250
`define EDGE_PULSE_CYC   (`EDGE_PULSE_NS / `CLK_PERIOD_NS)

`endif

//--- inc/int_status_pkg.sv
package int_status_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [2:0] {
    PULSE_IDLE = 3'b001,
    PULSE_HIGH = 3'b010,
    PULSE_HOLD = 3'b100
  } pulse_state_e;

endpackage

//--- hdl/edge_pulse_gen.sv
`timescale 1ns/1ps
`include "int_status_regs.svh"

module edge_pulse_gen
  import int_status_pkg::*;
(
  input  wire logic clk_in,     // device clock
  input  wire logic rst_in,     // sync reset, active high
  input  wire logic pending_in, // enabled interrupt condition
  output logic      pulse_out   // high for the fixed pulse time
);

  localparam logic [3:0] PULSE_LAST = 4'(`EDGE_PULSE_CYC - 1);

  pulse_state_e state_ff;
  pulse_state_e nxt_state;
  logic [3:0]   cnt_ff;
  logic [3:0]   nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      PULSE_IDLE: begin
        if (pending_in) begin
          nxt_state = PULSE_HIGH;
          nxt_cnt   = 4'h0;
        end
      end
      PULSE_HIGH: begin
        if (cnt_ff == PULSE_LAST) begin
          nxt_state = PULSE_HOLD;
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      // one pulse per assertion: rearm only after pending_in drops
      PULSE_HOLD: begin
        if (!pending_in) begin
          nxt_state = PULSE_IDLE;
        end
      end
      default: begin
        nxt_state = PULSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= PULSE_IDLE;
      cnt_ff   <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign pulse_out = (state_ff == PULSE_HIGH);

endmodule

//--- hdl/int_status_ctrl.sv
`timescale 1ns/1ps
`include "int_status_regs.svh"

module int_status_ctrl
  import int_status_pkg::*;
(
  input  wire logic        clk_in,        // 40 MHz device clock
  input  wire logic        rst_in,        // sync reset, active high
  input  wire reg_req_s    reg_req_in,    // byte register access
  input  wire logic [7:0]  src_event_in,  // source events, bits 7:0
  input  wire logic [23:0] gpio_event_in, // per-pin interrupt events
  output logic      [7:0]  rd_data_out,   // read data, next cycle
  output logic             int_out        // interrupt pin level
);

  logic [2:0]  ctl_ff;
  logic [2:0]  nxt_ctl;
  logic [8:0]  src_mask_ff;
  logic [8:0]  nxt_src_mask;
  logic [8:0]  src_flags_ff;
  logic [8:0]  nxt_src_flags;
  logic [23:0] gpio_mask_ff;
  logic [23:0] nxt_gpio_mask;
  logic [23:0] gpio_flags_ff;
  logic [23:0] nxt_gpio_flags;
  logic [7:0]  rd_data_ff;
  logic [7:0]  nxt_rd_data;
  logic        int_pin_ff;
  logic        nxt_int_pin;

  logic [23:0] gpio_clr;
  logic [8:0]  src_clr;
  logic [8:0]  src_set;
  logic        pending;
  logic        edge_pulse;
  logic        edge_arm;
  logic [8:0]  enabled_flags;
  logic        wr;
  logic [7:0]  addr;
  logic [7:0]  wdata;

  // one byte per access; address stepping stays in the serial slave
  assign wr    = reg_req_in.wr;
  assign addr  = reg_req_in.addr;
  assign wdata = reg_req_in.wdata;

  // control and mask registers
  // control msb byte holds nothing; writes there are dropped
  always_comb begin
    nxt_ctl       = ctl_ff;
    nxt_src_mask  = src_mask_ff;
    nxt_gpio_mask = gpio_mask_ff;
    if (wr) begin
      unique case (addr)
        `CTL_LSB_OFS: nxt_ctl = wdata[2:0];
        `SMASK_MSB_OFS: nxt_src_mask[8] = wdata[0];
        `SMASK_LSB_OFS: nxt_src_mask[7:0] = wdata;
        `GEN_MSB_OFS: nxt_gpio_mask[23:16] = wdata;
        `GEN_MID_OFS: nxt_gpio_mask[15:8] = wdata;
        `GEN_LSB_OFS: nxt_gpio_mask[7:0] = wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctl_ff       <= `CTL_RST;
      src_mask_ff  <= `SRC_MASK_RST;
      gpio_mask_ff <= `GPIO_MASK_RST;
    end else begin
      ctl_ff       <= nxt_ctl;
      src_mask_ff  <= nxt_src_mask;
      gpio_mask_ff <= nxt_gpio_mask;
    end
  end

  // write-one-to-clear strobes, decoded per byte lane
  always_comb begin
    gpio_clr = 24'h000000;
    src_clr  = 9'h000;
    if (wr) begin
      unique case (addr)
        `SRC_MSB_OFS: src_clr[8] = wdata[0];
        `SRC_LSB_OFS: src_clr[7:0] = wdata;
        `GFL_MSB_OFS: gpio_clr[23:16] = wdata;
        `GFL_MID_OFS: gpio_clr[15:8] = wdata;
        `GFL_LSB_OFS: gpio_clr[7:0] = wdata;
        default: begin
        end
      endcase
    end
  end

  // per-pin flags; a new event beats a clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < 24; i = i + 1) begin : g_gpio_flag
      always_comb begin
        nxt_gpio_flags[i] = gpio_event_in[i] |
                            (gpio_flags_ff[i] & ~gpio_clr[i]);
      end
    end
  endgenerate

  // gpio source flag follows only enabled pins, bits 7:0 follow their inputs
  always_comb begin
    src_set                = {1'b0, src_event_in};
    src_set[`SRC_GPIO_BIT] = |(gpio_event_in & gpio_mask_ff);
  end

  // a gpio pin flag cleared alone leaves the source flag up: host clears both
  genvar j;
  generate
    for (j = 0; j < 9; j = j + 1) begin : g_src_flag
      always_comb begin
        nxt_src_flags[j] = src_set[j] |
                           (src_flags_ff[j] & ~src_clr[j]);
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_flags_ff  <= `SRC_FLAGS_RST;
      gpio_flags_ff <= `GPIO_FLAGS_RST;
    end else begin
      src_flags_ff  <= nxt_src_flags;
      gpio_flags_ff <= nxt_gpio_flags;
    end
  end

  // register read port; reserved and unmapped bytes read zero
  // a read and a write to one byte in one cycle return the old value
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (reg_req_in.rd) begin
      unique case (addr)
        `CTL_LSB_OFS: nxt_rd_data = {5'h00, ctl_ff};
        `SMASK_MSB_OFS: nxt_rd_data = {7'h00, src_mask_ff[8]};
        `SMASK_LSB_OFS: nxt_rd_data = src_mask_ff[7:0];
        `SRC_MSB_OFS: nxt_rd_data = {7'h00, src_flags_ff[8]};
        `SRC_LSB_OFS: nxt_rd_data = src_flags_ff[7:0];
        `GEN_MSB_OFS: nxt_rd_data = gpio_mask_ff[23:16];
        `GEN_MID_OFS: nxt_rd_data = gpio_mask_ff[15:8];
        `GEN_LSB_OFS: nxt_rd_data = gpio_mask_ff[7:0];
        `GFL_MSB_OFS: nxt_rd_data = gpio_flags_ff[23:16];
        `GFL_MID_OFS: nxt_rd_data = gpio_flags_ff[15:8];
        `GFL_LSB_OFS: nxt_rd_data = gpio_flags_ff[7:0];
        default:      nxt_rd_data = 8'h00;
      endcase
    end
  end

  // global enable gates everything without touching the masks
  assign enabled_flags = src_flags_ff & src_mask_ff;
  assign pending       = ctl_ff[`CTL_GLOBAL_EN_BIT] &
                         (|enabled_flags);

  // engine armed only in edge mode, so level mode leaves no stale pulse
  assign edge_arm = pending & ctl_ff[`CTL_TYPE_BIT];

  // one fixed pulse per pending episode
  edge_pulse_gen u_edge_pulse (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .pending_in (edge_arm),
    .pulse_out  (edge_pulse)
  );

  // pin: level holds until the flag clears, edge gives one short pulse
  always_comb begin
    logic active;
    active = 1'b0;
    if (ctl_ff[`CTL_TYPE_BIT]) begin
      active = edge_pulse;
    end else begin
      active = pending;
    end
    // polarity applied last, shared by both modes
    nxt_int_pin = ctl_ff[`CTL_POL_BIT] ? active : ~active;
  end

  // pin registered so it never glitches while flags and masks settle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_ff <= `RD_DATA_RST;
      int_pin_ff <= `INT_PIN_RST;
    end else begin
      rd_data_ff <= nxt_rd_data;
      int_pin_ff <= nxt_int_pin;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign int_out     = int_pin_ff;

endmodule

//--- verif/int_status_properties.sv
`timescale 1ns/1ps
module int_status_properties
  import int_status_pkg::*;
(
  input  wire logic        clk_in,        // clock
  input  wire logic        rst_in,        // reset
  input  wire reg_req_s    reg_req_in,    // access
  input  wire logic [7:0]  src_event_in,  // events
  input  wire logic [23:0] gpio_event_in, // pin events
  input  wire logic [7:0]  rd_data_out,   // read data
  input  wire logic        int_out        // pin
);
  logic       rd;
  logic [7:0] ad;
  logic [7:0] wd;
  assign rd = reg_req_in.rd;
  assign ad = reg_req_in.addr;
  assign wd = reg_req_in.wdata;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_reset_idle: assert property (disable iff (1'b0)
    rst_in |=> rd_data_out == 8'h00 && int_out) else $error("reset");
  a_read_holds: assert property (
    !rd |=> $stable(rd_data_out)) else $error("read moved");
  a_unmapped_zero: assert property (
    rd && (ad < 8'h11 || ad > 8'h1b) |=> rd_data_out == 8'h00)
    else $error("unmapped");
  a_ctl_reserved: assert property (
    rd && ad == 8'h11 |=> rd_data_out[7:3] == 5'h00) else $error("ctl");
  a_msb_reserved: assert property (
    rd && (ad == 8'h12 || ad == 8'h14) |=> rd_data_out[7:1] == 7'h00)
    else $error("msb");
  a_src_event_seen: assert property (
    src_event_in != 8'h00 ##1 !reg_req_in.wr ##1 rd && ad == 8'h15
    |=> (rd_data_out & $past(src_event_in, 3)) == $past(src_event_in, 3))
    else $error("src flag");
  a_gpio_event_seen: assert property (
    gpio_event_in != 24'h0 ##1 !reg_req_in.wr ##1 rd && ad == 8'h1b
    |=> (rd_data_out & 8'($past(gpio_event_in, 3)))
    == 8'($past(gpio_event_in, 3))) else $error("gpio flag");
  a_w1c_clears: assert property (
    reg_req_in.wr && ad == 8'h15 && src_event_in == 8'h00 ##1
    !reg_req_in.wr && src_event_in == 8'h00 ##1 rd && ad == 8'h15
    |=> (rd_data_out & $past(wd, 3)) == 8'h00) else $error("w1c");
endmodule

bind int_status_ctrl int_status_properties chk (.clk_in, .rst_in,
  .reg_req_in, .src_event_in, .gpio_event_in, .rd_data_out, .int_out);

//--- verif/host_model.sv
`timescale 1ns/1ps
module host_model
  import int_status_pkg::*;
(
  input  wire logic       clk_in,  // clock
  input  wire logic [7:0] rd_in,   // read data
  output reg_req_s        req_out  // request
);
  initial req_out = '0;
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_in) req_out = {2'b10, a, d};
    @(negedge clk_in) req_out = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in) req_out = {2'b01, a, 8'h00};
    @(negedge clk_in) req_out = '0;
    d = rd_in;
  endtask
  // pin flags always cleared, so a masked pin leaves nothing stale
  task automatic service(output logic [8:0] s, output logic [23:0] g);
    logic [7:0] b;
    rd(8'h15, s[7:0]);
    rd(8'h14, b);
    s[8] = b[0];
    rd(8'h19, g[23:16]);
    rd(8'h1a, g[15:8]);
    rd(8'h1b, g[7:0]);
    wr(8'h19, g[23:16]);
    wr(8'h1a, g[15:8]);
    wr(8'h1b, g[7:0]);
    wr(8'h14, b);
    wr(8'h15, s[7:0]);
  endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import int_status_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  sev = 8'h00;
  logic [23:0] gev = '0;
  logic [7:0]  rdd;
  logic        pin;
  reg_req_s    req;
  int          mismatches = 0;
  int          n_tests = 0;
  logic [31:0] seed = 32'hf951;
  always #12.5 clk_in = ~clk_in;
  host_model host (.clk_in, .rd_in(rdd), .req_out(req));
  int_status_ctrl dut (.clk_in, .rst_in, .reg_req_in(req),
    .src_event_in(sev), .gpio_event_in(gev), .rd_data_out(rdd),
    .int_out(pin));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic close_out();
    $display("mismatches %0d of %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic ck8(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic ck1(input logic got, exp);
    ck8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic pulse(input logic [7:0] s, input logic [23:0] g);
    @(negedge clk_in);
    sev = s;
    gev = g;
    @(negedge clk_in);
    sev = 8'h00;
    gev = '0;
  endtask
  // a stuck pin ends the run instead of hanging it
  task automatic wait_pin(input logic v, output int n);
    for (n = 0; pin !== v; n++) begin
      if (n > 40) begin
        mismatches++;
        close_out();
      end
      @(negedge clk_in);
    end
  endtask
  initial begin
    logic [7:0]  d;
    logic [8:0]  s;
    logic [23:0] g, m, r;
    int          n;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    ck1(pin, 1'b1);
    for (int a = 32'h10; a < 32'h1d; a++) begin
      host.rd(8'(a), d);
      ck8(d, 8'h00);
    end
    seed = xs(seed);
    m = seed[23:0];
    for (int i = 0; i < 3; i++) host.wr(8'h18 - 8'(i), m[8*i +: 8]);
    for (int i = 0; i < 3; i++) begin
      host.rd(8'h18 - 8'(i), d);
      ck8(d, m[8*i +: 8]);
    end
    host.wr(8'h12, 8'hff);
    host.rd(8'h12, d);
    ck8(d, 8'h01);
    host.wr(8'h12, 8'h00);
    for (int b = 0; b < 8; b++) begin
      pulse(8'h01 << b, '0);
      host.rd(8'h15, d);
      ck8(d, 8'h01 << b);
      host.wr(8'h15, ~(8'h01 << b));
      host.rd(8'h15, d);
      ck8(d, 8'h01 << b);
      host.wr(8'h15, 8'h01 << b);
      host.rd(8'h15, d);
      ck8(d, 8'h00);
    end
    // event and clear in one cycle: the event must win
    fork
      pulse(8'h04, '0);
      host.wr(8'h15, 8'h04);
    join
    host.rd(8'h15, d);
    ck8(d, 8'h04);
    host.wr(8'h15, 8'h04);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      g = seed[31:8];
      pulse(8'h00, g);
      host.rd(8'h1b, d);
      ck8(d, g[7:0]);
      host.service(s, r);
      ck1(s[8], |(g & m));
      for (int i = 0; i < 3; i++) ck8(r[8*i +: 8], g[8*i +: 8]);
      host.service(s, r);
      ck1(|{s, r}, 1'b0);
    end
    host.wr(8'h13, 8'h02);
    for (int p = 1; p >= 0; p--) begin
      host.wr(8'h11, {5'h00, p[0], 2'b01});
      pulse(8'h01, '0);
      repeat (3) @(negedge clk_in);
      ck1(pin, ~p[0]);
      pulse(8'h02, '0);
      wait_pin(p[0], n);
      ck8(8'(n), 8'h01);
      host.wr(8'h15, 8'h01);
      ck1(pin, p[0]);
      host.wr(8'h11, {5'h00, p[0], 2'b00});
      @(negedge clk_in);
      ck1(pin, ~p[0]);
      host.wr(8'h11, {5'h00, p[0], 2'b01});
      host.wr(8'h15, 8'h02);
      wait_pin(~p[0], n);
      ck8(8'(n), 8'h01);
    end
    for (int p = 1; p >= 0; p--) begin
      host.wr(8'h15, 8'h02);
      host.wr(8'h11, {5'h00, p[0], 2'b11});
      pulse(8'h02, '0);
      wait_pin(p[0], n);
      wait_pin(~p[0], n);
      ck8(8'(n), 8'h0a);
      repeat (5) @(negedge clk_in);
      ck1(pin, ~p[0]);
    end
    // second reset in mid-run: pin idle, control cleared
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    ck1(pin, 1'b1);
    host.rd(8'h11, d);
    ck8(d, 8'h00);
    close_out();
  end
endmodule
